// ==== logic/pmc_monitor.sv ====
// Power monitor run control, settings, peak registers and alert routing
//
// Contract
// RULE1: Input peak holds max, upper nibble zero
// RULE2: Output peak holds max, upper nibble zero
// RULE3: Zero write clears peak; reset zero
// RULE4: Output peak at code D2, word
// RULE5: Input peak at code D1, word
// RULE6: Run control at D3, resets 01
// RULE7: Run bit one starts sampling
// RULE8: Single shot clears run bit itself
// RULE9: Continuous runs until host writes zero
// RULE10: Host stops monitor before changing settings
// RULE11: Settings byte at D4, resets AF
// RULE12: Settings bit7 picks single or continuous
// RULE13: Settings bit6 adds output voltage sample
// RULE14: Settings bit5 selects voltage range
// RULE15: Host writes settings bit4 as zero
// RULE16: Host keeps settings bit3 at one
// RULE17: Averaging field sets 1 to 128 samples
// RULE18: Alert enables at D6, resets 8000
// RULE19: Bit15 routes switch health flag, enabled
// RULE20: Bits14..9 route six fault flags
// RULE21: New larger voltage sample replaces peak
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_monitor
    import pmc_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input  wire logic              i_mclk,
    input  wire logic              i_arst_n,
    input  wire pmc_req_t          i_req,
    output logic                   o_ack,
    output logic                   o_nack,
    output logic [15:0]            o_rdata,
    output logic                   o_adc_start,
    output logic [1:0]             o_adc_channel,
    input  wire logic              i_adc_done,
    input  wire logic [DATA_W-1:0] i_adc_data,
    output logic                   o_voltage_range,
    output logic                   o_current_sense_en,
    output logic                   o_running,
    output logic                   o_cycle_done,
    output logic [DATA_W-1:0]      o_iout_avg,
    input  wire logic [6:0]        i_alert_flags,
    output logic                   o_alert
);

    localparam int ACC_W = DATA_W + `PMC_MAX_AVG_LOG2;

    if (DATA_W < 2 || DATA_W > 12) begin : g_chk
        $error("DATA_W must lie in 2..12");
    end

    // ============================================================
    // Registers
    logic                   run;
    pmc_settings_t          settings;
    logic [6:0]             alert_en;
    pmc_state_t             state;
    pmc_state_t             next_state;
    logic                   next_run;
    logic                   waiting;
    logic [6:0]             cnt;
    logic [ACC_W-1:0]       acc;
    logic [DATA_W-1:0]      peak_input_voltage;
    logic [DATA_W-1:0]      peak_output_voltage;
    logic [7:0]             last_code;
    logic [15:0]            next_rdata;
    logic                   known;

    // ============================================================
    // Command decode
    wire req_wr  = i_req.valid & i_req.write;
    wire req_rd  = i_req.valid & ~i_req.write;
    wire wr_run  = req_wr & (i_req.code == `PMC_CODE_RUN_CTRL);
    wire wr_set  = req_wr & (i_req.code == `PMC_CODE_SETTINGS);
    wire wr_alt  = req_wr & (i_req.code == `PMC_CODE_ALERT2);
    wire wr_zero = (i_req.wdata == `PMC_RST_PEAK);
    wire clr_vin = req_wr & wr_zero
                 & (i_req.code == `PMC_CODE_PEAK_INPUT_VOLTAGE);     // [RULE5]
    wire clr_output_voltage_pin = req_wr & wr_zero
                  & (i_req.code == `PMC_CODE_PEAK_OUTPUT_VOLTAGE);   // [RULE4]

    always_comb begin
        known      = 1'b1;
        next_rdata = 16'h0000;
        case (i_req.code)
            `PMC_CODE_PEAK_INPUT_VOLTAGE:                                // [RULE5]
                next_rdata = 16'(peak_input_voltage);                    // [RULE1]
            `PMC_CODE_PEAK_OUTPUT_VOLTAGE:                               // [RULE4]
                next_rdata = 16'(peak_output_voltage);                   // [RULE2]
            `PMC_CODE_RUN_CTRL:
                next_rdata = {15'h0000, run};                  // [RULE6]
            `PMC_CODE_SETTINGS:
                next_rdata = {8'h00, settings};                // [RULE11]
            `PMC_CODE_ALERT2:
                next_rdata = {alert_en, 9'h000};               // [RULE18]
            default:
                known = 1'b0;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ack     <= 1'b0;
            o_nack    <= 1'b0;
            o_rdata   <= 16'h0000;
            last_code <= 8'h00;
        end else begin
            o_ack  <= i_req.valid & known;
            o_nack <= i_req.valid & ~known;
            if (i_req.valid) begin
                last_code <= i_req.code;
            end
            if (req_rd && known) begin
                o_rdata <= next_rdata;
            end
        end
    end

    // ============================================================
    // Settings and alert enables
    // Settings are used live; the host stops the monitor first [RULE10]
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            settings <= `PMC_RST_SETTINGS;                     // [RULE11]
        end else if (wr_set) begin
            settings <= i_req.wdata[7:0];                      // [RULE11]
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            alert_en <= 7'(`PMC_RST_ALERT2
                           >> `PMC_ALERT2_LO);                 // [RULE18]
        end else if (wr_alt) begin
            alert_en <= i_req.wdata
                        [`PMC_ALERT2_HI:`PMC_ALERT2_LO];       // [RULE20]
        end
    end

    assign o_voltage_range    = settings.range;                // [RULE14]
    assign o_current_sense_en = settings.isense_en;            // [RULE16]

    // ============================================================
    // Sampling arithmetic
    wire              active    = (state != PMC_IDLE);
    wire              sample_in = waiting & i_adc_done;
    wire [6:0]        n_last    = 7'((8'h01 << settings.avg) - 8'h01);
    wire              last_smp  = sample_in & (cnt == n_last); // [RULE17]
    wire [ACC_W-1:0]  sum       = acc + ACC_W'(i_adc_data);
    wire [DATA_W-1:0] avg_val   = DATA_W'(sum >> settings.avg); // [RULE17]
    wire              cycle_end = last_smp
        & ((state == PMC_CONV_VIN && !settings.output_voltage_pin_sel)
        | (state == PMC_CONV_OUTPUT_VOLTAGE_PIN));
    wire              vin_done  = last_smp & (state == PMC_CONV_VIN);
    wire              output_voltage_pin_done = last_smp & (state == PMC_CONV_OUTPUT_VOLTAGE_PIN);

    // ============================================================
    // Run bit
    // A host write in the same cycle as the self clear wins
    always_comb begin
        next_run = run;
        if (cycle_end && !settings.mode) begin
            next_run = 1'b0;                                   // [RULE8]
        end
        if (wr_run) begin
            next_run = i_req.wdata[`PMC_RUN_BIT];              // [RULE9]
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run <= 1'(`PMC_RST_RUN_CTRL >> `PMC_RUN_BIT);      // [RULE6]
        end else begin
            run <= next_run;
        end
    end

    // ============================================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            PMC_IDLE: begin
                if (run) begin
                    next_state = PMC_CONV_I;                   // [RULE7]
                end
            end
            PMC_CONV_I: begin
                if (last_smp) begin
                    next_state = PMC_CONV_VIN;
                end
            end
            PMC_CONV_VIN: begin
                if (last_smp) begin
                    if (settings.output_voltage_pin_sel) begin
                        next_state = PMC_CONV_OUTPUT_VOLTAGE_PIN;            // [RULE13]
                    end else if (next_run && settings.mode) begin
                        next_state = PMC_CONV_I;               // [RULE12]
                    end else begin
                        next_state = PMC_IDLE;
                    end
                end
            end
            PMC_CONV_OUTPUT_VOLTAGE_PIN: begin
                if (last_smp) begin
                    if (next_run && settings.mode) begin
                        next_state = PMC_CONV_I;               // [RULE12]
                    end else begin
                        next_state = PMC_IDLE;
                    end
                end
            end
            default: next_state = PMC_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= PMC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Converter handshake: one start, then wait for done
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_adc_start   <= 1'b0;
            o_adc_channel <= `PMC_CH_CURRENT;
            waiting       <= 1'b0;
        end else begin
            o_adc_start <= active & ~waiting & ~o_adc_start;   // [RULE7]
            if (active && !waiting && !o_adc_start) begin
                case (state)
                    PMC_CONV_VIN:  o_adc_channel <= `PMC_CH_VIN;
                    PMC_CONV_OUTPUT_VOLTAGE_PIN: o_adc_channel <= `PMC_CH_OUTPUT_VOLTAGE_PIN;
                    default:       o_adc_channel <= `PMC_CH_CURRENT;
                endcase
            end
            if (o_adc_start) begin
                waiting <= 1'b1;
            end else if (i_adc_done) begin
                waiting <= 1'b0;
            end
        end
    end

    // Averaging accumulator
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= 7'h00;
            acc <= '0;
        end else if (sample_in) begin
            cnt <= last_smp ? 7'h00 : cnt + 7'h01;             // [RULE17]
            acc <= last_smp ? '0 : sum;
        end
    end

    // Results
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_iout_avg   <= '0;
            o_cycle_done <= 1'b0;
        end else begin
            o_cycle_done <= cycle_end;
            if (last_smp && state == PMC_CONV_I) begin
                o_iout_avg <= avg_val;
            end
        end
    end

    assign o_running = active;

    // ============================================================
    // Peak registers
    pmc_peak_hold #(
        .DATA_W         (DATA_W)
    ) u_peak_input_voltage (
        .i_mclk         (i_mclk),
        .i_arst_n       (i_arst_n),
        .i_sample_valid (vin_done),                            // [RULE21]
        .i_sample       (avg_val),
        .i_clear        (clr_vin),                             // [RULE3]
        .o_peak         (peak_input_voltage)
    );

    pmc_peak_hold #(
        .DATA_W         (DATA_W)
    ) u_peak_output_voltage (
        .i_mclk         (i_mclk),
        .i_arst_n       (i_arst_n),
        .i_sample_valid (output_voltage_pin_done),                           // [RULE21]
        .i_sample       (avg_val),
        .i_clear        (clr_output_voltage_pin),                            // [RULE3]
        .o_peak         (peak_output_voltage)
    );

    // ============================================================
    // Alert routing
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_alert <= 1'b0;
        end else begin
            o_alert <= |(i_alert_flags & alert_en);   // [RULE19] [RULE20]
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    sequence s_enter_cycle;
        state == PMC_CONV_I ##1 o_adc_start;
    endsequence

    start_sampling_a: assert property (                        // [RULE7]
        state == PMC_IDLE && run |=> s_enter_cycle)
        else $error("run bit did not start sampling");

    single_clear_a: assert property (                          // [RULE8]
        cycle_end && !settings.mode && !wr_run |=> !run ##1 !active)
        else $error("single shot did not stop");

    cont_keep_a: assert property (                             // [RULE9]
        cycle_end && settings.mode && run && !wr_run
        |=> run && state == PMC_CONV_I)
        else $error("continuous mode stopped by itself");

    output_voltage_pin_step_a: assert property (                             // [RULE13]
        vin_done |=> (state == PMC_CONV_OUTPUT_VOLTAGE_PIN) == $past(settings.output_voltage_pin_sel))
        else $error("output voltage step wrong");

    run_read_a: assert property (                              // [RULE6]
        req_rd && i_req.code == `PMC_CODE_RUN_CTRL
        |=> o_ack && o_rdata[15:1] == 15'h0000)
        else $error("run control upper bits not zero");

    peak_read_a: assert property (                             // [RULE1]
        o_ack && !$past(i_req.write) && (last_code ==
        `PMC_CODE_PEAK_INPUT_VOLTAGE || last_code == `PMC_CODE_PEAK_OUTPUT_VOLTAGE)
        |-> o_rdata[15:12] == 4'h0)
        else $error("peak upper nibble not zero");

    avg_count_a: assert property (                             // [RULE17]
        sample_in && !last_smp |=> cnt == $past(cnt) + 7'h01
        && cnt <= n_last)
        else $error("averaging count wrong");

    alert_route_a: assert property (                           // [RULE20]
        |(i_alert_flags & alert_en) |=> o_alert)
        else $error("enabled flag did not raise alert");

    unmapped_a: assert property (
        i_req.valid && !known |=> o_nack && !o_ack)
        else $error("unknown code not refused");

endmodule : pmc_monitor

// ==== logic/pmc_peak_hold.sv ====
// Peak-hold register for one voltage channel
`timescale 1ns/10ps
module pmc_peak_hold #(
    parameter int DATA_W = 12
) (
    input  wire logic              i_mclk,
    input  wire logic              i_arst_n,
    input  wire logic              i_sample_valid,
    input  wire logic [DATA_W-1:0] i_sample,
    input  wire logic              i_clear,
    output logic      [DATA_W-1:0] o_peak
);

    // A sample arriving with a clear restarts tracking from that sample
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_peak <= '0;                                        // [RULE3]
        end else if (i_clear) begin
            o_peak <= i_sample_valid ? i_sample : '0;            // [RULE3]
        end else if (i_sample_valid && i_sample > o_peak) begin
            o_peak <= i_sample;                                  // [RULE21]
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    peak_track_a: assert property (                              // [RULE21]
        i_sample_valid && !i_clear && i_sample > o_peak
        |=> o_peak == $past(i_sample))
        else $error("peak did not take larger sample");

    peak_clear_a: assert property (                              // [RULE3]
        i_clear && !i_sample_valid |=> o_peak == '0)
        else $error("peak not cleared by zero write");

    peak_hold_a: assert property (                               // [RULE21]
        !i_clear |=> o_peak >= $past(o_peak))
        else $error("peak fell without a clear");

endmodule : pmc_peak_hold

// ==== pkg/pmc_pkg.sv ====
// Types shared by the power monitor control logic
package pmc_pkg;

    // ============================================================
    // Command request from the bus front end
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } pmc_req_t;

    // ============================================================
    // Layout of the monitor settings byte
    typedef struct packed {
        logic       mode;
        logic       output_voltage_pin_sel;
        logic       range;
        logic       rsvd4;
        logic       isense_en;
        logic [2:0] avg;
    } pmc_settings_t;

    // ============================================================
    // Sampling sequencer states
    typedef enum logic [1:0] {
        PMC_IDLE,
        PMC_CONV_I,
        PMC_CONV_VIN,
        PMC_CONV_OUTPUT_VOLTAGE_PIN
    } pmc_state_t;

endpackage : pmc_pkg

// ==== pkg/pmc_regs.svh ====
// Command codes, reset values, field positions and timing of the monitor
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ============================================================
// Command codes
`define PMC_CODE_PEAK_INPUT_VOLTAGE   8'hD1
`define PMC_CODE_PEAK_OUTPUT_VOLTAGE  8'hD2
`define PMC_CODE_RUN_CTRL   8'hD3
`define PMC_CODE_SETTINGS   8'hD4
`define PMC_CODE_ALERT2     8'hD6

// ============================================================
// Reset values
`define PMC_RST_PEAK        16'h0000
`define PMC_RST_RUN_CTRL    8'h01
`define PMC_RST_SETTINGS    8'hAF
`define PMC_RST_ALERT2      16'h8000

// ============================================================
// Field positions
`define PMC_RUN_BIT         0
`define PMC_ALERT2_HI       15
`define PMC_ALERT2_LO       9
`define PMC_PEAK_HI         11
`define PMC_PEAK_LO         0

// ============================================================
// Converter channel codes
`define PMC_CH_CURRENT      2'h0
`define PMC_CH_VIN          2'h1
`define PMC_CH_OUTPUT_VOLTAGE_PIN         2'h2

// ============================================================
// Timing
`define PMC_CLK_NS          100
`define PMC_MAX_AVG_LOG2    7

`endif

// ==== tb/pmc_adc_model.sv ====
// Converter model answering the monitor's conversion requests
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_adc_model (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_start,
    input  wire logic [1:0]  i_channel,
    input  wire logic [3:0]  i_latency,
    input  wire logic [11:0] i_val_cur,
    input  wire logic [11:0] i_val_vin,
    input  wire logic [11:0] i_val_output_voltage_pin,
    output logic             o_done,
    output logic [11:0]      o_data
);
    // ============================================================
    // Conversion timer
    logic       busy;
    logic [3:0] cnt;
    logic [1:0] chan;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy   <= 1'b0;
            cnt    <= 4'h0;
            chan   <= 2'h0;
            o_done <= 1'b0;
            o_data <= 12'h000;
        end else begin
            o_done <= 1'b0;
            // Data line toggles every cycle outside the result cycle
            o_data <= ~o_data;
            if (i_start) begin
                busy <= 1'b1;
                cnt  <= i_latency;
                chan <= i_channel;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy   <= 1'b0;
                o_done <= 1'b1;
                o_data <= (chan == `PMC_CH_CURRENT) ? i_val_cur :
                          (chan == `PMC_CH_VIN) ? i_val_vin : i_val_output_voltage_pin;
            end
        end
    end
endmodule : pmc_adc_model

// ==== tb/tb.sv ====
// Self-checking testbench of the power monitor control logic
`timescale 1ns/10ps
`include "pmc_regs.svh"
module tb
    import pmc_pkg::*;
;
    logic        i_mclk;
    logic        i_arst_n;
    pmc_req_t    i_req;
    logic        o_ack;
    logic        o_nack;
    logic [15:0] o_rdata;
    logic        o_adc_start;
    logic [1:0]  o_adc_channel;
    logic        adc_done;
    logic [11:0] adc_data;
    logic        o_voltage_range;
    logic        o_current_sense_en;
    logic        o_running;
    logic        o_cycle_done;
    logic [11:0] o_iout_avg;
    logic [6:0]  i_alert_flags;
    logic        o_alert;
    logic [3:0]  adc_latency;
    logic [11:0] val_cur;
    logic [11:0] val_vin;
    logic [11:0] val_output_voltage_pin;
    int          n_errors;
    int          num_checks;
    int          cycles;
    int          n_start [3];

    // ============================================================
    // Clock, design and converter
    initial i_mclk = 1'b0;
    always #50 i_mclk = ~i_mclk;

    pmc_monitor #(.DATA_W(12)) i_pmc_monitor (
        .i_mclk             (i_mclk),
        .i_arst_n           (i_arst_n),
        .i_req              (i_req),
        .o_ack              (o_ack),
        .o_nack             (o_nack),
        .o_rdata            (o_rdata),
        .o_adc_start        (o_adc_start),
        .o_adc_channel      (o_adc_channel),
        .i_adc_done         (adc_done),
        .i_adc_data         (adc_data),
        .o_voltage_range    (o_voltage_range),
        .o_current_sense_en (o_current_sense_en),
        .o_running          (o_running),
        .o_cycle_done       (o_cycle_done),
        .o_iout_avg         (o_iout_avg),
        .i_alert_flags      (i_alert_flags),
        .o_alert            (o_alert)
    );

    pmc_adc_model i_pmc_adc_model (
        .i_mclk     (i_mclk),
        .i_arst_n   (i_arst_n),
        .i_start    (o_adc_start),
        .i_channel  (o_adc_channel),
        .i_latency  (adc_latency),
        .i_val_cur  (val_cur),
        .i_val_vin  (val_vin),
        .i_val_output_voltage_pin (val_output_voltage_pin),
        .o_done     (adc_done),
        .o_data     (adc_data)
    );

    always @(negedge i_mclk) begin
        if (o_adc_start === 1'b1 && o_adc_channel < 2'h3)
            n_start[o_adc_channel]++;
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            finish_test();
        end
    end

    // ============================================================
    // Tasks
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t ns: %s", $time, msg);
        end
    endtask : check

    task automatic cmd(input logic wr, input logic [7:0] code,
                       input logic [15:0] wd, input logic [15:0] exp,
                       input logic nk);
        i_req = '{1'b1, wr, code, wd};
        @(negedge i_mclk);
        i_req.valid = 1'b0;
        check(o_ack === ~nk && o_nack === nk, "command answer");
        if (!wr && !nk)
            check(o_rdata === exp, "read data");
        // Idle edge so the next request never retouches valid at once
        @(negedge i_mclk);
    endtask : cmd

    task automatic wait_cycle();
        int k;
        k = 0;
        while (o_cycle_done !== 1'b1 && k < 6000) begin
            @(negedge i_mclk);
            k++;
        end
        check(k < 6000, "sampling cycle end");
    endtask : wait_cycle

    task automatic run_single(input logic [7:0] cfg, input logic [3:0] lat);
        int n;
        n = 1 << cfg[2:0];
        adc_latency = lat;
        cmd(1, `PMC_CODE_SETTINGS, {8'h00, cfg}, 0, 0);
        cmd(0, `PMC_CODE_SETTINGS, 0, {8'h00, cfg}, 0);
        check(o_voltage_range === cfg[5], "range pin");
        check(o_current_sense_en === cfg[3], "sense pin");
        n_start = '{default: 0};
        cmd(1, `PMC_CODE_RUN_CTRL, 16'h0001, 0, 0);
        wait_cycle();
        @(negedge i_mclk);
        check(o_running === 1'b0, "single shot stop");
        cmd(0, `PMC_CODE_RUN_CTRL, 0, 16'h0000, 0);
        check(n_start[0] == n && n_start[1] == n, "sample count");
        check(n_start[2] == (cfg[6] ? n : 0), "output sample");
        check(o_iout_avg === val_cur, "current average");
    endtask : run_single

    task automatic alert_sweep(input logic [15:0] en);
        for (int i = 0; i < 7; i++) begin
            i_alert_flags = 7'h01 << i;
            @(negedge i_mclk);
            check(o_alert === en[9 + i], "alert routing");
        end
        i_alert_flags = 7'h00;
        @(negedge i_mclk);
    endtask : alert_sweep

    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // ============================================================
    // Main sequence
    initial begin
        i_arst_n      = 1'b0;
        i_req         = '0;
        i_alert_flags = 7'h00;
        adc_latency   = 4'h1;
        val_cur       = 12'h064;
        val_vin       = 12'h123;
        val_output_voltage_pin      = 12'h234;
        n_errors      = 0;
        num_checks    = 0;
        cycles        = 0;
        n_start       = '{default: 0};
        repeat (4) @(negedge i_mclk);
        i_arst_n = 1'b1;
        @(negedge i_mclk);
        cmd(0, `PMC_CODE_PEAK_INPUT_VOLTAGE, 0, `PMC_RST_PEAK, 0);
        cmd(0, `PMC_CODE_PEAK_OUTPUT_VOLTAGE, 0, `PMC_RST_PEAK, 0);
        cmd(0, `PMC_CODE_RUN_CTRL, 0, {8'h00, `PMC_RST_RUN_CTRL}, 0);
        cmd(0, `PMC_CODE_SETTINGS, 0, {8'h00, `PMC_RST_SETTINGS}, 0);
        check(o_voltage_range === 1'b1, "range reset");
        cmd(0, `PMC_CODE_ALERT2, 0, `PMC_RST_ALERT2, 0);
        cmd(0, 8'hD5, 0, 0, 1);
        cmd(1, 8'hD0, 16'h0000, 0, 1);
        // Default continuous run with full averaging
        wait_cycle();
        check(n_start[0] == 128 && n_start[1] == 128, "default avg");
        check(n_start[2] == 0, "no output sample");
        @(negedge i_mclk);
        cmd(0, `PMC_CODE_PEAK_INPUT_VOLTAGE, 0, 16'h0123, 0);
        cmd(0, `PMC_CODE_RUN_CTRL, 0, 16'h0001, 0);
        cmd(1, `PMC_CODE_RUN_CTRL, 16'h0000, 0, 0);
        wait_cycle();
        @(negedge i_mclk);
        check(o_running === 1'b0, "host stop");
        // Peak clearing
        cmd(1, `PMC_CODE_PEAK_INPUT_VOLTAGE, 16'h0555, 0, 0);
        cmd(0, `PMC_CODE_PEAK_INPUT_VOLTAGE, 0, 16'h0123, 0);
        cmd(1, `PMC_CODE_PEAK_INPUT_VOLTAGE, 16'h0000, 0, 0);
        cmd(0, `PMC_CODE_PEAK_INPUT_VOLTAGE, 0, 16'h0000, 0);
        run_single(8'h49, 4'h6);
        cmd(0, `PMC_CODE_PEAK_INPUT_VOLTAGE, 0, 16'h0123, 0);
        cmd(0, `PMC_CODE_PEAK_OUTPUT_VOLTAGE, 0, 16'h0234, 0);
        val_vin  = 12'h050;
        val_output_voltage_pin = 12'hFFF;
        run_single(8'h49, 4'h0);
        cmd(0, `PMC_CODE_PEAK_INPUT_VOLTAGE, 0, 16'h0123, 0);
        cmd(0, `PMC_CODE_PEAK_OUTPUT_VOLTAGE, 0, 16'h0FFF, 0);
        cmd(1, `PMC_CODE_PEAK_OUTPUT_VOLTAGE, 16'h0000, 0, 0);
        cmd(0, `PMC_CODE_PEAK_OUTPUT_VOLTAGE, 0, 16'h0000, 0);
        for (int k = 0; k < 8; k++)
            run_single({5'b00101, k[2:0]}, 4'h0);
        // Continuous with output voltage
        cmd(1, `PMC_CODE_SETTINGS, 16'h00C8, 0, 0);
        cmd(1, `PMC_CODE_RUN_CTRL, 16'h0001, 0, 0);
        wait_cycle();
        @(negedge i_mclk);
        wait_cycle();
        @(negedge i_mclk);
        cmd(0, `PMC_CODE_RUN_CTRL, 0, 16'h0001, 0);
        cmd(1, `PMC_CODE_RUN_CTRL, 16'h0000, 0, 0);
        wait_cycle();
        @(negedge i_mclk);
        check(o_running === 1'b0, "continuous stop");
        cmd(1, `PMC_CODE_RUN_CTRL, 16'h00FE, 0, 0);
        cmd(0, `PMC_CODE_RUN_CTRL, 0, 16'h0000, 0);
        // Alert routing
        alert_sweep(`PMC_RST_ALERT2);
        cmd(1, `PMC_CODE_ALERT2, 16'hFFFF, 0, 0);
        cmd(0, `PMC_CODE_ALERT2, 0, 16'hFE00, 0);
        cmd(1, `PMC_CODE_ALERT2, 16'h7E00, 0, 0);
        alert_sweep(16'h7E00);
        finish_test();
    end
endmodule : tb
